// ### msf_pkg.sv
/*
 * constants, types and helper functions for the slave frame handler.
 * assumes one 125 mhz system clock and an external byte transceiver.
 */
`default_nettype none
package msf_pkg;
    // ------------------------------------------------------------
    // function codes and frame layout
    // ------------------------------------------------------------
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WRITE = 8'h10;
    localparam logic [8:0] IDX_ADDR = 9'h000;
    localparam logic [8:0] IDX_FN = 9'h001;
    localparam logic [8:0] IDX_SREG_HI = 9'h002;
    localparam logic [8:0] IDX_SREG_LO = 9'h003;
    localparam logic [8:0] IDX_CNT_HI = 9'h004;
    localparam logic [8:0] IDX_CNT_LO = 9'h005;
    localparam logic [8:0] IDX_BC = 9'h006;
    localparam logic [8:0] IDX_DATA = 9'h007;
    localparam logic [8:0] RD_QUERY_LEN = 9'h008;
    localparam logic [8:0] WR_FIXED_LEN = 9'h009;
    localparam logic [8:0] RD_RSP_HDR = 9'h003;
    localparam logic [8:0] WR_RSP_LEN = 9'h008;
    localparam logic [8:0] CRC_LEN = 9'h002;
    localparam logic [8:0] MAX_FRAME = 9'h108;
    localparam logic [8:0] MAX_DATA = 9'h0fe;
    localparam logic [15:0] MAX_REGS = 16'h007f;
    // ------------------------------------------------------------
    // checksum
    // ------------------------------------------------------------
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam int CRC_STEPS = 8;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int RESP_DLY_US = 1000;
    localparam int RESP_DLY_CYC = RESP_DLY_US * CLK_MHZ;
    // ------------------------------------------------------------
    // value packing
    // ------------------------------------------------------------
    localparam int FLT_SIGN = 31;
    localparam int FLT_EXP_HI = 30;
    localparam int FLT_EXP_LO = 23;
    localparam int FLT_MAN_HI = 22;
    localparam logic [8:0] FLT_BIAS = 9'h07f;
    localparam logic [31:0] FLT_MARKER = 32'h8000_0000;

    typedef enum {ST_RX, ST_CHECK, ST_WRITE, ST_WAIT, ST_TX} msf_state_e;

    typedef struct packed {
        msf_state_e st;
        logic [8:0] idx;
        logic ovf;
        logic [7:0] addr;
        logic [7:0] fn;
        logic [15:0] sreg;
        logic [15:0] cnt;
        logic [7:0] bc;
        logic [15:0] crc;
        logic [15:0] crc_h1;
        logic [15:0] crc_h2;
        logic [15:0] tail;
        logic [6:0] wr_i;
        logic [16:0] dly;
        logic [8:0] tx_i;
        logic [8:0] tx_len;
        logic [15:0] tcrc;
        logic [7:0] held;
        logic [15:0] rd_addr;
        logic tx_valid;
        logic [7:0] tx_byte;
        logic wr_en;
        logic [15:0] wr_addr;
        logic [15:0] wr_data;
        logic pair_valid;
        logic [31:0] pair_raw;
    } msf_state_s;

    // byte folded into the high half, eight right shifts with mask
    function automatic logic [15:0] crc_byte(input logic [15:0] c_in,
                                             input logic [7:0] b);
        logic [15:0] c;
        logic lsb;
        c = c_in ^ {b, 8'h00}; // R10
        for (int k = 0; k < CRC_STEPS; k++) begin
            lsb = c[0];
            c = {1'b0, c[15:1]}; // R11
            if (lsb) begin
                c = c ^ CRC_POLY; // R8 R11
            end
        end
        return c;
    endfunction : crc_byte

    // sign-magnitude word to two's complement
    function automatic logic [31:0] sm_to_int(input logic [31:0] v);
        logic [31:0] mag;
        mag = {1'b0, v[30:0]};
        return v[FLT_SIGN] ? (~mag + 32'h0000_0001) : mag;
    endfunction : sm_to_int
endpackage : msf_pkg
`default_nettype wire

// ### msf_frame.sv
/*
 * slave frame handler: parses read and write queries, checks address,
 * checksum and map range, applies writes, and sends the response.
 * assumes bytes and a frame-end pulse come from a receiver on i_clk,
 * and that a register store answers i_rd_data in the same cycle.
 */
// What this block does
// [R1] read query addr,fn 3,start,count,crc; reply addr,fn,count,data,crc
// [R2] write query adds byte count and data; reply echoes header, new crc
// [R3] start register sent high byte first, then low byte
// [R4] register count sent high byte first, then low byte
// [R5] byte count is one byte, 0 to 255
// [R6] data bytes equal twice the register count
// [R7] frame ends with checksum, high byte then low byte
// [R8] checksum polynomial 0xa001 applied as xor mask on right shift
// [R9] checksum register preset to all ones before the first byte
// [R10] each byte xored into the high byte of the checksum register
// [R11] shift right zero-filled, xor polynomial if the dropped bit was one
// [R12] eight steps per byte; final value is the frame checksum
// [R13] 8-bit values occupy the upper or lower register byte
// [R14] 16-bit unsigned value fills one whole register
// [R15] 32-bit integer: lower-numbered register holds bits 31 to 16
// [R16] 32-bit integer is sign-magnitude; both zeros legal
// [R17] floats use the standard single-precision format
// [R18] float spans two registers; sign, exponent, top mantissa first
// [R19] negative-zero float is a special marker, not a number
// [R20] exponent stored with bias 127, true range -126 to 127
// [R21] mantissa normalised with a hidden leading one
// [R22] slave only; answers only if all addressed registers are mapped
// [R23] on multidrop lines wait a response delay, default 1 ms
// [R24] frames with a foreign address or bad checksum are dropped
`timescale 1ns/100ps
`default_nettype none
module msf_frame #(
    parameter int RESP_DLY_CYC = msf_pkg::RESP_DLY_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_dev_addr,
    input wire logic i_multidrop,
    input wire logic [15:0] i_map_first,
    input wire logic [15:0] i_map_last,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_end,
    output logic o_tx_valid,
    output logic [7:0] o_tx_byte,
    input wire logic i_tx_ready,
    output logic [15:0] o_rd_addr,
    input wire logic [15:0] i_rd_data,
    output logic o_wr_en,
    output logic [15:0] o_wr_addr,
    output logic [15:0] o_wr_data,
    output logic o_pair_valid,
    output logic [31:0] o_pair_raw,
    output logic [31:0] o_pair_int,
    output logic o_pair_marker,
    output logic [8:0] o_pair_exp
);
    // ------------------------------------------------------------
    // state and write buffer
    // ------------------------------------------------------------
    localparam logic [16:0] DLY_LOAD = 17'(RESP_DLY_CYC - 1);

    msf_pkg::msf_state_s s_ff;
    msf_pkg::msf_state_s nxt_s;
    logic [15:0] mem_ff [0:126];
    logic [15:0] mem_rd;
    logic [7:0] body;
    logic [8:0] dpos;
    logic [8:0] wpos;
    logic [16:0] last_reg;
    logic range_ok;
    logic len_ok;
    logic accept;

    assign mem_rd = mem_ff[s_ff.wr_i];
    assign wpos = s_ff.idx - msf_pkg::IDX_DATA;

    // ------------------------------------------------------------
    // query acceptance
    // ------------------------------------------------------------
    always_comb begin
        last_reg = {1'b0, s_ff.sreg} + {1'b0, s_ff.cnt} - 17'h0_0001;
        range_ok = (s_ff.cnt != 16'h0000) && (s_ff.cnt <= msf_pkg::MAX_REGS)
            && (s_ff.sreg >= i_map_first)
            && (last_reg <= {1'b0, i_map_last}); // R22
        len_ok = ((s_ff.fn == msf_pkg::FN_READ)
                  && (s_ff.idx == msf_pkg::RD_QUERY_LEN)) // R1
            || ((s_ff.fn == msf_pkg::FN_WRITE)
                && (s_ff.idx == msf_pkg::WR_FIXED_LEN + {1'b0, s_ff.bc})
                && (s_ff.bc == {s_ff.cnt[6:0], 1'b0})); // R2 R5 R6
        accept = !s_ff.ovf && len_ok && range_ok
            && (s_ff.addr == i_dev_addr)
            && (s_ff.crc_h2 == s_ff.tail); // R7 R24
    end

    // ------------------------------------------------------------
    // response byte source
    // ------------------------------------------------------------
    always_comb begin
        dpos = s_ff.tx_i - msf_pkg::RD_RSP_HDR;
        body = 8'h00;
        case (s_ff.tx_i)
            9'h000: body = s_ff.addr;
            9'h001: body = s_ff.fn;
            default: begin
                if (s_ff.fn == msf_pkg::FN_READ) begin
                    if (s_ff.tx_i == msf_pkg::IDX_SREG_HI) begin
                        body = s_ff.bc;
                    end else if (!dpos[0]) begin
                        body = i_rd_data[15:8]; // R14
                    end else begin
                        body = s_ff.held;
                    end
                end else begin
                    case (s_ff.tx_i)
                        msf_pkg::IDX_SREG_HI: body = s_ff.sreg[15:8]; // R3
                        msf_pkg::IDX_SREG_LO: body = s_ff.sreg[7:0];
                        msf_pkg::IDX_CNT_HI: body = s_ff.cnt[15:8]; // R4
                        msf_pkg::IDX_CNT_LO: body = s_ff.cnt[7:0];
                        default: body = 8'h00;
                    endcase
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.wr_en = 1'b0;
        nxt_s.pair_valid = 1'b0;
        case (s_ff.st)
            msf_pkg::ST_RX: begin
                if (i_rx_valid) begin
                    if (s_ff.idx == msf_pkg::IDX_ADDR) begin
                        nxt_s.crc = msf_pkg::crc_byte(msf_pkg::CRC_INIT,
                                                      i_rx_byte); // R9
                        nxt_s.crc_h1 = msf_pkg::CRC_INIT;
                    end else begin
                        nxt_s.crc = msf_pkg::crc_byte(s_ff.crc,
                                                      i_rx_byte); // R12
                        nxt_s.crc_h1 = s_ff.crc;
                    end
                    nxt_s.crc_h2 = s_ff.crc_h1;
                    nxt_s.tail = {s_ff.tail[7:0], i_rx_byte}; // R7
                    if (s_ff.idx == msf_pkg::MAX_FRAME) begin
                        nxt_s.ovf = 1'b1;
                    end else begin
                        nxt_s.idx = s_ff.idx + 9'h001;
                    end
                    case (s_ff.idx)
                        msf_pkg::IDX_ADDR: nxt_s.addr = i_rx_byte;
                        msf_pkg::IDX_FN: nxt_s.fn = i_rx_byte;
                        msf_pkg::IDX_SREG_HI: nxt_s.sreg[15:8] = i_rx_byte;
                        msf_pkg::IDX_SREG_LO: nxt_s.sreg[7:0] = i_rx_byte;
                        msf_pkg::IDX_CNT_HI: nxt_s.cnt[15:8] = i_rx_byte;
                        msf_pkg::IDX_CNT_LO: nxt_s.cnt[7:0] = i_rx_byte;
                        msf_pkg::IDX_BC: nxt_s.bc = i_rx_byte;
                        default: nxt_s.bc = s_ff.bc;
                    endcase
                end else if (i_rx_end && (s_ff.idx != 9'h000)) begin
                    nxt_s.st = msf_pkg::ST_CHECK;
                end
            end
            msf_pkg::ST_CHECK: begin
                nxt_s.idx = 9'h000;
                nxt_s.ovf = 1'b0;
                nxt_s.wr_i = 7'h00;
                nxt_s.dly = i_multidrop ? DLY_LOAD : 17'h0_0000; // R23
                if (!accept) begin
                    nxt_s.st = msf_pkg::ST_RX; // R24
                end else if (s_ff.fn == msf_pkg::FN_WRITE) begin
                    nxt_s.st = msf_pkg::ST_WRITE;
                end else begin
                    nxt_s.bc = {s_ff.cnt[6:0], 1'b0}; // R6
                    nxt_s.st = msf_pkg::ST_WAIT;
                end
            end
            msf_pkg::ST_WRITE: begin
                nxt_s.wr_en = 1'b1;
                nxt_s.wr_addr = s_ff.sreg + {9'h000, s_ff.wr_i};
                nxt_s.wr_data = mem_rd; // R14
                if (s_ff.wr_i[0]) begin
                    nxt_s.pair_valid = 1'b1;
                    nxt_s.pair_raw = {s_ff.wr_data, mem_rd}; // R15 R18
                end
                if ({9'h000, s_ff.wr_i} == s_ff.cnt - 16'h0001) begin
                    nxt_s.st = msf_pkg::ST_WAIT;
                end else begin
                    nxt_s.wr_i = s_ff.wr_i + 7'h01;
                end
            end
            msf_pkg::ST_WAIT: begin
                if (s_ff.dly == 17'h0_0000) begin
                    nxt_s.st = msf_pkg::ST_TX;
                    nxt_s.tx_i = 9'h000;
                    nxt_s.tcrc = msf_pkg::CRC_INIT; // R9
                    nxt_s.tx_len = (s_ff.fn == msf_pkg::FN_READ)
                        ? msf_pkg::RD_RSP_HDR + {1'b0, s_ff.bc}
                          + msf_pkg::CRC_LEN
                        : msf_pkg::WR_RSP_LEN;
                end else begin
                    nxt_s.dly = s_ff.dly - 17'h0_0001; // R23
                end
            end
            msf_pkg::ST_TX: begin
                if (!s_ff.tx_valid || i_tx_ready) begin
                    if (s_ff.tx_i == s_ff.tx_len) begin
                        nxt_s.tx_valid = 1'b0;
                        nxt_s.st = msf_pkg::ST_RX;
                    end else begin
                        nxt_s.tx_valid = 1'b1;
                        nxt_s.tx_i = s_ff.tx_i + 9'h001;
                        nxt_s.rd_addr = s_ff.sreg
                            + {8'h00, dpos[8:1]} + 16'h0001;
                        if (s_ff.tx_i == s_ff.tx_len - 9'h002) begin
                            nxt_s.tx_byte = s_ff.tcrc[15:8]; // R7
                        end else if (s_ff.tx_i == s_ff.tx_len - 9'h001) begin
                            nxt_s.tx_byte = s_ff.tcrc[7:0];
                        end else begin
                            nxt_s.tx_byte = body; // R1 R2
                            nxt_s.tcrc = msf_pkg::crc_byte(s_ff.tcrc,
                                                           body); // R12
                            if ((s_ff.fn == msf_pkg::FN_READ)
                                && (s_ff.tx_i >= msf_pkg::RD_RSP_HDR)
                                && !dpos[0]) begin
                                nxt_s.held = i_rd_data[7:0]; // R13
                            end
                        end
                        if (s_ff.tx_i < msf_pkg::RD_RSP_HDR) begin
                            nxt_s.rd_addr = s_ff.sreg;
                        end
                    end
                end
            end
            default: nxt_s.st = msf_pkg::ST_RX;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_ff <= '0;
            s_ff.st <= msf_pkg::ST_RX;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // write data held until the whole frame is proven good
    always_ff @(posedge i_clk) begin
        if ((s_ff.st == msf_pkg::ST_RX) && i_rx_valid
            && (s_ff.fn == msf_pkg::FN_WRITE)
            && (s_ff.idx >= msf_pkg::IDX_DATA)
            && (wpos < msf_pkg::MAX_DATA)) begin
            if (!wpos[0]) begin
                mem_ff[wpos[7:1]][15:8] <= i_rx_byte; // R13
            end else begin
                mem_ff[wpos[7:1]][7:0] <= i_rx_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_tx_valid = s_ff.tx_valid;
    assign o_tx_byte = s_ff.tx_byte;
    assign o_rd_addr = s_ff.rd_addr;
    assign o_wr_en = s_ff.wr_en;
    assign o_wr_addr = s_ff.wr_addr;
    assign o_wr_data = s_ff.wr_data;
    assign o_pair_valid = s_ff.pair_valid;
    assign o_pair_raw = s_ff.pair_raw;
    assign o_pair_int = msf_pkg::sm_to_int(s_ff.pair_raw); // R16
    assign o_pair_marker = (s_ff.pair_raw == msf_pkg::FLT_MARKER); // R19
    assign o_pair_exp = {1'b0, s_ff.pair_raw[msf_pkg::FLT_EXP_HI:
        msf_pkg::FLT_EXP_LO]} - msf_pkg::FLT_BIAS; // R17 R20 R21

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_checking;
        s_ff.st == msf_pkg::ST_CHECK;
    endsequence
    sequence s_back_rx;
        (s_ff.st == msf_pkg::ST_RX) && !o_tx_valid;
    endsequence

    chk_foreign_addr: assert property ( // R24
        s_checking and (s_ff.addr != i_dev_addr) |=> s_back_rx)
        else $error("foreign address frame not dropped");
    chk_bad_crc: assert property ( // R24
        s_checking and (s_ff.crc_h2 != s_ff.tail) |=> s_back_rx)
        else $error("bad checksum frame not dropped");
    chk_write_count: assert property ( // R6
        s_checking and (s_ff.fn == msf_pkg::FN_WRITE)
        and (s_ff.bc != {s_ff.cnt[6:0], 1'b0}) |=> s_back_rx)
        else $error("byte count mismatch accepted");
    chk_map_range: assert property ( // R22
        s_checking and !range_ok |=> s_back_rx ##1 !o_wr_en)
        else $error("unmapped registers accepted");
    chk_resp_delay: assert property ( // R23
        $rose(s_ff.st == msf_pkg::ST_WAIT) && i_multidrop
        |-> (!o_tx_valid)[*8])
        else $error("response sent before delay");
    chk_crc_preset: assert property ( // R9
        (s_ff.st == msf_pkg::ST_RX) && i_rx_valid && (s_ff.idx == 9'h000)
        |=> s_ff.crc == msf_pkg::crc_byte(16'hffff, $past(i_rx_byte)))
        else $error("checksum not preset to all ones");
    chk_first_write: assert property ( // R2
        s_checking and accept and (s_ff.fn == msf_pkg::FN_WRITE)
        |=> ##1 o_wr_en && (o_wr_addr == $past(s_ff.sreg, 2)))
        else $error("write walk did not start at start register");
    chk_echo_start: assert property ( // R3
        o_tx_valid && (s_ff.fn == msf_pkg::FN_WRITE)
        && (s_ff.tx_i == 9'h003) |-> o_tx_byte == s_ff.sreg[15:8])
        else $error("start register high byte not echoed first");
    chk_sm_negative: assert property ( // R16
        o_pair_valid && o_pair_raw[31]
        |-> o_pair_int == (32'h0000_0000 - {1'b0, o_pair_raw[30:0]}))
        else $error("sign-magnitude conversion wrong");
endmodule : msf_frame
`default_nettype wire

// ### msf_peer.sv
/*
 * partner model: register store and response byte sink.
 * assumes the bench clock and the block's read and transmit ports.
 */
`timescale 1ns/100ps
`default_nettype none
module msf_peer (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [15:0] i_rd_addr,
    output logic [15:0] o_rd_data,
    output logic o_tx_ready
);
    logic [7:0] lfsr_ff;
    // ------------------------------------------------------------
    // store answers in the same cycle
    // ------------------------------------------------------------
    assign o_rd_data = i_rd_addr ^ 16'hc3a5;
    // ------------------------------------------------------------
    // sink stalls on a pseudo-random pattern
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lfsr_ff <= 8'h5b;
        end else begin
            lfsr_ff <= {lfsr_ff[6:0], ^{lfsr_ff[7], lfsr_ff[5:3]}};
        end
    end
    assign o_tx_ready = lfsr_ff[0] | lfsr_ff[3];
endmodule : msf_peer
`default_nettype wire

// ### tb_top.sv
/*
 * bench: sends queries, checks replies, writes and register pairs.
 * assumes msf_pkg, msf_frame and msf_peer are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int DLY = 10;
    logic i_clk, i_rst, md, rxv, rxe, txv, txr, wen, pv, mk;
    logic [7:0] rxb, txb;
    logic [15:0] ra, rdd, wa, wd;
    logic [31:0] praw, pint;
    logic [8:0] pexp;
    logic [31:0] r;
    int err_count, n_tests, seed, n0, n1;
    logic [7:0] txq[$], fr[$], ex[$];
    logic [73:0] wq[$], pq[$];

    msf_frame #(.RESP_DLY_CYC(DLY)) i_msf_frame (.i_clk(i_clk),
        .i_rst(i_rst), .i_dev_addr(8'h11), .i_multidrop(md),
        .i_map_first(16'h0100), .i_map_last(16'h01ff), .i_rx_valid(rxv),
        .i_rx_byte(rxb), .i_rx_end(rxe), .o_tx_valid(txv),
        .o_tx_byte(txb), .i_tx_ready(txr), .o_rd_addr(ra),
        .i_rd_data(rdd), .o_wr_en(wen), .o_wr_addr(wa), .o_wr_data(wd),
        .o_pair_valid(pv), .o_pair_raw(praw), .o_pair_int(pint),
        .o_pair_marker(mk), .o_pair_exp(pexp));
    msf_peer i_msf_peer (.i_clk(i_clk), .i_rst(i_rst), .i_rd_addr(ra),
        .o_rd_data(rdd), .o_tx_ready(txr));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // ------------------------------------------------------------
    // model functions and compare tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] crc_of(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (f[i]) begin
            c = c ^ {f[i], 8'h00};
            for (int k = 0; k < 8; k++) begin
                c = {1'b0, c[15:1]} ^ (c[0] ? 16'ha001 : 16'h0000);
            end
        end
        return c;
    endfunction : crc_of
    function automatic logic [73:0] pair_of(input logic [31:0] v);
        logic [31:0] m;
        m = {1'b0, v[30:0]};
        return {v, (v[31] ? 32'h0000_0000 - m : m),
            (v === 32'h8000_0000), ({1'b0, v[30:23]} - 9'h07f)};
    endfunction : pair_of
    task automatic cmp_out(input string nm, input logic [73:0] e, s);
        n_tests++;
        if (e !== s) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp_out
    task automatic cmp_lat(input int e, s);
        n_tests++;
        if (e != s) begin
            err_count++;
            $display("Error latency expected %0d seen %0d", e, s);
        end
    endtask : cmp_lat
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // ------------------------------------------------------------
    // monitor
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_rst === 1'b0 && txv === 1'b1 && txr === 1'b1) begin
            cmp_out("tx_byte", txq.size() ? 74'(txq.pop_front())
                : 74'(~txb), 74'(txb));
        end
        if (i_rst === 1'b0 && wen === 1'b1) begin
            cmp_out("write", wq.size() ? wq.pop_front()
                : ~74'({wa, wd}), 74'({wa, wd}));
        end
        if (i_rst === 1'b0 && pv === 1'b1) begin
            cmp_out("pair", pq.size() ? pq.pop_front()
                : ~{praw, pint, mk, pexp}, {praw, pint, mk, pexp});
        end
    end
    // ------------------------------------------------------------
    // driver tasks
    // ------------------------------------------------------------
    task automatic send(input bit bad);
        logic [15:0] c;
        c = crc_of(fr) ^ {15'h0000, bad};
        fr.push_back(c[15:8]);
        fr.push_back(c[7:0]);
        foreach (fr[i]) begin
            @(posedge i_clk);
            rxv <= 1'b1;
            rxb <= fr[i];
        end
        @(posedge i_clk);
        rxv <= 1'b0;
        rxe <= 1'b1;
        @(posedge i_clk);
        rxe <= 1'b0;
        fr.delete();
    endtask : send
    task automatic expect_tx();
        logic [15:0] c;
        c = crc_of(ex);
        foreach (ex[i]) txq.push_back(ex[i]);
        txq.push_back(c[15:8]);
        txq.push_back(c[7:0]);
    endtask : expect_tx
    task automatic drain();
        int n;
        n = 0;
        while ((txq.size() + wq.size() + pq.size() != 0 || txv !== 1'b0)
            && n < 3000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 3000) begin
            err_count++;
            $display("Error drain expected idle seen busy");
        end
        repeat (4) @(posedge i_clk);
    endtask : drain
    task automatic lat(output int n);
        n = 0;
        #1;
        while (txv !== 1'b1 && n < 500) begin
            @(posedge i_clk);
            #1;
            n++;
        end
    endtask : lat
    task automatic rd(input logic [15:0] s, input logic [7:0] n);
        fr = '{8'h11, 8'h03, s[15:8], s[7:0], 8'h00, n};
        ex = '{8'h11, 8'h03, {n[6:0], 1'b0}};
        for (int i = 0; i < n; i++) begin
            r[15:0] = (s + 16'(i)) ^ 16'hc3a5;
            ex.push_back(r[15:8]);
            ex.push_back(r[7:0]);
        end
        expect_tx();
        send(1'b0);
    endtask : rd
    task automatic wr(input logic [15:0] s, input logic [7:0] n, bit z);
        logic [15:0] d, p;
        fr = '{8'h11, 8'h10, s[15:8], s[7:0], 8'h00, n, {n[6:0], 1'b0}};
        for (int i = 0; i < n; i++) begin
            d = z ? {~i[0], 15'h0000} : 16'($random(seed));
            fr.push_back(d[15:8]);
            fr.push_back(d[7:0]);
            wq.push_back(74'({s + 16'(i), d}));
            if (i[0]) pq.push_back(pair_of({p, d}));
            p = d;
        end
        ex = '{8'h11, 8'h10, s[15:8], s[7:0], 8'h00, n};
        expect_tx();
        send(1'b0);
        drain();
    endtask : wr
    task automatic bad(input logic [7:0] a, f, logic [15:0] s,
        logic [7:0] n, bit b);
        fr = '{a, f, s[15:8], s[7:0], 8'h00, n};
        send(b);
        drain();
    endtask : bad
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        seed = 40173;
        err_count = 0;
        n_tests = 0;
        i_rst = 1'b1;
        {md, rxv, rxe, rxb} = 11'h000;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(16'h012c, 8'h12);
        lat(n0);
        drain();
        md <= 1'b1;
        rd(16'h012c, 8'h12);
        lat(n1);
        drain();
        cmp_lat(DLY - 1, n1 - n0);
        md <= 1'b0;
        r = $random(seed);
        rd(16'h0100 | {9'h000, r[6:0]}, {2'b00, r[13:8]} + 8'h01);
        drain();
        rd(16'h01f0, 8'h10);
        drain();
        wr(16'h0132, 8'h08, 1'b0);
        wr(16'h0140, 8'h02, 1'b1);
        wr(16'h0181, 8'h7f, 1'b0);
        bad(8'h12, 8'h03, 16'h0100, 8'h02, 1'b0);
        bad(8'h11, 8'h03, 16'h0100, 8'h02, 1'b1);
        bad(8'h11, 8'h05, 16'h0100, 8'h02, 1'b0);
        bad(8'h11, 8'h03, 16'h00ff, 8'h02, 1'b0);
        bad(8'h11, 8'h03, 16'h01f0, 8'h11, 1'b0);
        bad(8'h11, 8'h03, 16'h0100, 8'h00, 1'b0);
        fr = '{8'h11, 8'h10, 8'h01, 8'h00, 8'h00, 8'h01, 8'h04,
            8'h00, 8'h00, 8'h00, 8'h00};
        send(1'b0);
        drain();
        rd(16'h0150, 8'h01);
        drain();
        conclude();
    end
    initial begin
        #400000;
        err_count++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
